//--- hdl/liu_map.svh
// Register offsets, field positions, reset values and timing counts of the line
// interface digital side. Assumes a 250 MHz system clock and a 32-bit Wishbone bus.
`ifndef LIU_MAP_SVH
`define LIU_MAP_SVH

// Byte addresses of the word registers.
`define ADR_LIVE       8'h00
`define ADR_EVENT      8'h04
`define ADR_CLEAR      8'h08
`define ADR_ENABLE     8'h0C
`define ADR_CTRL       8'h10

// Bit positions in the event, clear, enable, live and control registers.
`define EV_LOS         0
`define EV_CLKMISS     1
`define EV_OVERFLOW    2
`define LIVE_MODE_LSB  4
`define CTRL_DS1       0

// Reset values.
`define ENABLE_RESET   3'h0
`define CTRL_RESET     1'h0
`define PIN_RESET      10'h002

// Timing: system clock period, clock loss window and line bit periods.
`define CLK_PERIOD_PS  4000
`define CLK_LOSS_NS    2000
`define CLK_LOSS_CYC   ((`CLK_LOSS_NS * 1000) / `CLK_PERIOD_PS)
`define E1_BIT_PS      488281
`define DS1_BIT_PS     647668
`define E1_BIT_CYC     (`E1_BIT_PS / `CLK_PERIOD_PS)
`define DS1_BIT_CYC    (`DS1_BIT_PS / `CLK_PERIOD_PS)
`define LOS_ZEROS      175

`endif

//--- hdl/liu_pkg.sv
// Types shared by the line interface digital side.
// Assumes nothing beyond a SystemVerilog compiler.
package liu_pkg;

   // Loopback selection decoded from the two select pins.
   typedef enum logic [1:0] {LOOP_NORMAL, LOOP_DIGITAL, LOOP_REMOTE, LOOP_LOCAL} loop_mode_t;

   // One bipolar symbol as a pair of NRZ rails.
   typedef struct packed {
      logic pos;
      logic neg;
   } rail_t;

   // Slow pins after synchronisation; test_n sits at bit 1.
   typedef struct packed {
      logic rx_pos;
      logic rx_neg;
      logic analog_los;
      logic tx_pos;
      logic tx_neg;
      logic all_ones;
      logic sel_hi;
      logic sel_lo;
      logic test_n;
      logic ja_ovf;
   } pin_t;

endpackage

//--- hdl/liu_clock_watch.sv
// Synchroniser, rising edge detector and activity watchdog for one clock pin.
// Assumes the watched clock is much slower than clk_i.
`timescale 1ns/1ps
module liu_clock_watch #(
   parameter int TIMEOUT = 500
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      absent_o
);
   localparam int CW = $clog2(TIMEOUT + 1);

   logic          s1_reg, s2_reg, s3_reg;
   logic [CW-1:0] cnt_reg, cnt_next;

   // Any edge restarts the window; the count saturates so absent stays a level.
   always_comb begin
      cnt_next = cnt_reg;
      if (s2_reg != s3_reg) begin
         cnt_next = '0;
      end else if (cnt_reg != CW'(TIMEOUT)) begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         cnt_reg <= '0;
      end else begin
         s1_reg  <= pin_i;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         cnt_reg <= cnt_next;
      end
   end

   assign level_o  = s2_reg;
   assign rise_o   = s2_reg & ~s3_reg;
   assign absent_o = (cnt_reg == CW'(TIMEOUT));
endmodule

//--- hdl/t1_e1_liu_digital_side.sv
// Digital side of a single-channel DS1/E1 line interface: receive recovery, loss flags,
// transmit rails, all-ones, loopbacks, test tristate and a classic Wishbone slave.
// Assumes every pin is asynchronous to clk_i; the tristate itself is outside.
//
// Operation
// - Loss flag rises on analog loss or on a long run of zero bits.
// - Loss flag stays high until the loss condition has gone.
// - A receive clock recovered from incoming marks goes to the terminal.
// - Received bits leave as positive and negative NRZ rails.
// - Transmit rails are sent bipolar on the tip and ring outputs.
// - Clock missing flag rises when transmit or attenuator clock is absent.
// - Test input low takes the drive off every output pin.
// - Remote loopback wins over the all-ones request.
// - Selects 00 give normal operation, 01 digital loopback.
// - Selects 10 give remote loopback, 11 local loopback.
// - Overflow flag rises when the jitter buffer overflows.
`timescale 1ns/1ps
`include "liu_map.svh"
module t1_e1_liu_digital_side
   import liu_pkg::*;
#(
   parameter int LOS_ZEROS = `LOS_ZEROS,
   parameter int CLK_LOSS  = `CLK_LOSS_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire logic        line_rx_positive_in_i,
   input  wire logic        line_rx_negative_in_i,
   input  wire logic        analog_los_i,
   input  wire logic        tx_clock_in_i,
   input  wire logic        tx_pos_rail_data_i,
   input  wire logic        tx_neg_rail_data_i,
   input  wire logic        external_reference_clock_i,
   input  wire logic        send_all_ones_request_i,
   input  wire logic        loopback_select_hi_i,
   input  wire logic        loopback_select_lo_i,
   input  wire logic        in_circuit_test_n_i,
   input  wire logic        ja_clock_i,
   input  wire logic        ja_overflow_i,
   output logic             rx_clock_o,
   output logic             rx_pos_rail_data_o,
   output logic             rx_neg_rail_data_o,
   output logic             rx_signal_lost_flag_o,
   output logic             line_tx_positive_out_o,
   output logic             line_tx_negative_out_o,
   output logic             clock_missing_flag_o,
   output logic             jitter_buffer_overflow_flag_o,
   output logic             pin_oe_o
);

   // Decode of the two loopback select pins.
   function automatic loop_mode_t decode_loop(input logic hi, input logic lo);
      case ({hi, lo})
         2'b00:   decode_loop = LOOP_NORMAL;
         2'b01:   decode_loop = LOOP_DIGITAL;
         2'b10:   decode_loop = LOOP_REMOTE;
         default: decode_loop = LOOP_LOCAL;
      endcase
   endfunction

   pin_t       pin_raw, s1_reg, pins;
   loop_mode_t mode;
   logic       tx_level, tx_rise, tx_absent, ext_rise, ja_absent;
   logic [7:0] bit_cyc, half;
   logic       ones_active;
   rail_t      src;
   logic       mark_rise, bit_stb, digital_los, los_cond;
   logic [7:0] phase_reg, phase_next, zeros_reg, zeros_next;
   logic       rxclk_reg, rxclk_next;
   rail_t      mark_prev_reg;
   rail_t      seen_reg, seen_next, rxo_reg, rxo_next;
   rail_t      txcap_reg, txcap_next, line_reg, line_next;
   logic       pol_reg, pol_next;
   logic [2:0] flag_reg, flag_next, event_reg, event_next, enable_reg, enable_next;
   logic       ctrl_ds1_reg, ctrl_ds1_next, ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic       wr_take;

   // Slow pins pass two flip-flops; the first stage is read only by the second.
   assign pin_raw = '{rx_pos: line_rx_positive_in_i, rx_neg: line_rx_negative_in_i,
                      analog_los: analog_los_i, tx_pos: tx_pos_rail_data_i,
                      tx_neg: tx_neg_rail_data_i, all_ones: send_all_ones_request_i,
                      sel_hi: loopback_select_hi_i, sel_lo: loopback_select_lo_i,
                      test_n: in_circuit_test_n_i, ja_ovf: ja_overflow_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= pin_t'(`PIN_RESET);
         pins   <= pin_t'(`PIN_RESET);
      end else begin
         s1_reg <= pin_raw;
         pins   <= s1_reg;
      end
   end

   // Watchdogs for the terminal transmit clock and attenuator clock; only the rising edge of the reference clock is used.
   liu_clock_watch #(.TIMEOUT(CLK_LOSS)) u_tx_watch (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .pin_i    (tx_clock_in_i),
      .level_o  (tx_level),
      .rise_o   (tx_rise),
      .absent_o (tx_absent)
   );

   liu_clock_watch #(.TIMEOUT(CLK_LOSS)) u_ext_watch (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .pin_i    (external_reference_clock_i),
      .level_o  (),
      .rise_o   (ext_rise),
      .absent_o ()
   );

   liu_clock_watch #(.TIMEOUT(CLK_LOSS)) u_ja_watch (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .pin_i    (ja_clock_i),
      .level_o  (),
      .rise_o   (),
      .absent_o (ja_absent)
   );

   // Mode and rate; remote loopback takes priority over the all-ones request.
   assign mode        = decode_loop(pins.sel_hi, pins.sel_lo);
   assign ones_active = pins.all_ones && (mode != LOOP_REMOTE);
   assign bit_cyc     = ctrl_ds1_reg ? 8'(`DS1_BIT_CYC) : 8'(`E1_BIT_CYC);
   assign half        = {1'b0, bit_cyc[7:1]};

   // Local loopback feeds the transmitted symbols back into the receiver.
   assign src       = (mode == LOOP_LOCAL) ? line_reg : rail_t'({pins.rx_pos, pins.rx_neg});
   // Rises are taken per rail, so looped-back NRZ marks of alternate polarity still count.
   assign mark_rise = |(src & ~mark_prev_reg);
   assign bit_stb   = (phase_reg == half) && !mark_rise;
   assign digital_los = (zeros_reg == 8'(LOS_ZEROS));
   assign los_cond  = pins.analog_los | digital_los;

   // Receive recovery: each mark re-aligns the bit phase, the bit is decided at mid
   // phase. A plain phase reset was chosen over a loop filter to keep area small.
   always_comb begin
      phase_next = (phase_reg >= bit_cyc - 8'h01) ? 8'h00 : phase_reg + 8'h01;
      seen_next  = seen_reg;
      zeros_next = zeros_reg;
      rxo_next   = rxo_reg;
      if (mark_rise) begin
         phase_next = 8'h00;
         seen_next  = rail_t'(seen_reg | src);
      end
      if (bit_stb) begin
         seen_next = '0;
         if (seen_reg != 2'b00) begin
            zeros_next = 8'h00;
         end else if (!digital_los) begin
            zeros_next = zeros_reg + 8'h01;
         end
      end
      rxclk_next = (phase_next < half);
      if (mode == LOOP_DIGITAL) begin
         rxclk_next = tx_level;
         rxo_next   = txcap_reg;
      end else if (bit_stb) begin
         rxo_next   = seen_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg     <= 8'h00;
         zeros_reg     <= 8'h00;
         seen_reg      <= '0;
         rxo_reg       <= '0;
         rxclk_reg     <= 1'b0;
         mark_prev_reg <= '0;
      end else begin
         phase_reg     <= phase_next;
         zeros_reg     <= zeros_next;
         seen_reg      <= seen_next;
         rxo_reg       <= rxo_next;
         rxclk_reg     <= rxclk_next;
         mark_prev_reg <= src;
      end
   end

   // Transmit: terminal rails on the transmit clock, recovered rails in remote
   // loopback, or alternating marks on the reference clock while all-ones runs.
   always_comb begin
      txcap_next = txcap_reg;
      line_next  = line_reg;
      pol_next   = pol_reg;
      if (tx_rise) begin
         txcap_next = rail_t'({pins.tx_pos, pins.tx_neg});
      end
      if (mode == LOOP_REMOTE) begin
         if (bit_stb) begin
            line_next = seen_reg;
         end
      end else if (ones_active) begin
         if (ext_rise) begin
            line_next = rail_t'({~pol_reg, pol_reg});
            pol_next  = ~pol_reg;
         end
      end else if (tx_rise) begin
         line_next = rail_t'({pins.tx_pos, pins.tx_neg});
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         txcap_reg <= '0;
         line_reg  <= '0;
         pol_reg   <= 1'b0;
      end else begin
         txcap_reg <= txcap_next;
         line_reg  <= line_next;
         pol_reg   <= pol_next;
      end
   end

   // Flags follow their conditions one cycle late; events are their rising edges.
   // Set wins over a clear written in the same cycle, so no event is lost.
   assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];

   always_comb begin
      flag_next[`EV_LOS]      = los_cond;
      flag_next[`EV_CLKMISS]  = tx_absent | ja_absent;
      flag_next[`EV_OVERFLOW] = pins.ja_ovf;
      event_next  = event_reg;
      enable_next = enable_reg;
      ctrl_ds1_next = ctrl_ds1_reg;
      if (wr_take && wb_adr_i[7:2] == 6'(`ADR_CLEAR >> 2)) begin
         event_next = event_reg & ~wb_dat_i[2:0];
      end
      if (wr_take && wb_adr_i[7:2] == 6'(`ADR_ENABLE >> 2)) begin
         enable_next = wb_dat_i[2:0];
      end
      if (wr_take && wb_adr_i[7:2] == 6'(`ADR_CTRL >> 2)) begin
         ctrl_ds1_next = wb_dat_i[`CTRL_DS1];
      end
      event_next = event_next | (flag_next & ~flag_reg);
   end

   // Classic Wishbone: ack one cycle after the request, dropped the cycle after.
   always_comb begin
      ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
      rdat_next = 32'h0000_0000;
      case (wb_adr_i[7:2])
         6'(`ADR_LIVE >> 2):   rdat_next = {26'h000_0000, mode, 1'b0, flag_reg};
         6'(`ADR_EVENT >> 2):  rdat_next = {29'h0000_0000, event_reg};
         6'(`ADR_ENABLE >> 2): rdat_next = {29'h0000_0000, enable_reg};
         6'(`ADR_CTRL >> 2):   rdat_next = {31'h0000_0000, ctrl_ds1_reg};
         default:          rdat_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_reg     <= 3'h0;
         event_reg    <= 3'h0;
         enable_reg   <= `ENABLE_RESET;
         ctrl_ds1_reg <= `CTRL_RESET;
         ack_reg      <= 1'b0;
         rdat_reg     <= 32'h0000_0000;
      end else begin
         flag_reg     <= flag_next;
         event_reg    <= event_next;
         enable_reg   <= enable_next;
         ctrl_ds1_reg <= ctrl_ds1_next;
         ack_reg      <= ack_next;
         rdat_reg     <= rdat_next;
      end
   end

   // Outputs; the pad ring tristates all pin outputs while pin_oe_o is low.
   assign wb_ack_o  = ack_reg;
   assign wb_dat_o  = rdat_reg;
   assign irq_o     = |(event_reg & enable_reg);
   assign rx_clock_o             = rxclk_reg;
   assign rx_pos_rail_data_o     = rxo_reg.pos;
   assign rx_neg_rail_data_o     = rxo_reg.neg;
   assign rx_signal_lost_flag_o  = flag_reg[`EV_LOS];
   assign line_tx_positive_out_o = line_reg.pos;
   assign line_tx_negative_out_o = line_reg.neg;
   assign clock_missing_flag_o   = flag_reg[`EV_CLKMISS];
   assign jitter_buffer_overflow_flag_o = flag_reg[`EV_OVERFLOW];
   assign pin_oe_o  = pins.test_n;

   // Checks on the behaviour above.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_test_low;
      !in_circuit_test_n_i [*3];
   endsequence

   sequence s_ones_mark;
      ext_rise && ones_active;
   endsequence

   AST_LOS_SET: assert property (los_cond |=> rx_signal_lost_flag_o)
      else $error("Loss flag did not rise after a loss condition.");
   AST_LOS_CLEAR: assert property (rx_signal_lost_flag_o && !los_cond |=> !rx_signal_lost_flag_o)
      else $error("Loss flag did not follow the cleared condition.");
   AST_RXCLK: assert property (bit_stb && mode != LOOP_DIGITAL |=> !rx_clock_o)
      else $error("Receive clock not low after the decision point.");
   AST_RXDATA: assert property (bit_stb && mode != LOOP_DIGITAL
                                |=> rx_pos_rail_data_o == $past(seen_reg.pos))
      else $error("Receive rail does not carry the recovered bit.");
   AST_TXDATA: assert property (tx_rise && mode == LOOP_NORMAL && !pins.all_ones
                                |=> line_tx_positive_out_o == $past(pins.tx_pos))
      else $error("Transmit rail does not follow the terminal data.");
   AST_CLKMISS: assert property (tx_absent |=> clock_missing_flag_o)
      else $error("Missing transmit clock not flagged.");
   AST_TEST: assert property (s_test_low |-> !pin_oe_o)
      else $error("Output drive not removed in test mode.");
   AST_ONES: assert property (s_ones_mark |=> line_tx_positive_out_o != line_tx_negative_out_o)
      else $error("All-ones did not send a mark.");
   AST_REMOTE: assert property (mode == LOOP_REMOTE && bit_stb
                                |=> line_reg == $past(seen_reg))
      else $error("Remote loopback did not win over all-ones.");
   AST_DECODE_DIG: assert property (!pins.sel_hi && pins.sel_lo |-> mode == LOOP_DIGITAL)
      else $error("Select 01 not decoded as digital loopback.");
   AST_DECODE_REM: assert property (pins.sel_hi && !pins.sel_lo |-> mode == LOOP_REMOTE)
      else $error("Select 10 not decoded as remote loopback.");
   AST_OVERFLOW: assert property (pins.ja_ovf |=> jitter_buffer_overflow_flag_o)
      else $error("Buffer overflow not flagged.");
   AST_ALTERNATE: assert property (s_ones_mark |=> line_tx_positive_out_o != $past(pol_reg))
      else $error("All-ones marks did not alternate.");
   AST_EVENT_SET: assert property (flag_next[`EV_LOS] && !flag_reg[`EV_LOS]
                                   |=> event_reg[`EV_LOS])
      else $error("Loss event not captured.");

endmodule

//--- testbench/liu_far_end.sv
// Far-end model: terminal transmit clock, attenuator clock, reference clock, AMI line source.
// Assumes clk_i is the 250 MHz system clock; every output moves just after its rising edge.
`timescale 1ns/1ps
module liu_far_end #(
   parameter int HALF = 61
) (
   input  wire logic clk_i,
   input  wire logic tx_run_i,
   input  wire logic ja_run_i,
   input  wire logic marks_run_i,
   output logic      tx_clock_o = 1'h0,
   output logic      ref_clock_o = 1'h0,
   output logic      ja_clock_o = 1'h0,
   output logic      line_pos_o = 1'h0,
   output logic      line_neg_o = 1'h0
);
   // Every output starts low so the block sees defined pins from time zero.
   int   cnt = 0;
   logic odd = 1'h0;

   // Stopped clocks stand still low, which is how a missing clock looks on the pin.
   always @(posedge clk_i) begin
      cnt <= (cnt == 4 * HALF - 1) ? 0 : cnt + 1;
      if (cnt % HALF == HALF - 1) begin
         tx_clock_o <= tx_run_i & ~tx_clock_o;
         ja_clock_o <= ja_run_i & ~ja_clock_o;
      end
      if (cnt % HALF == HALF / 3) begin
         ref_clock_o <= ~ref_clock_o;
      end
      // Marks return to zero at mid-bit and alternate in polarity.
      if (cnt % (2 * HALF) == 0 && marks_run_i) begin
         line_pos_o <= ~odd;
         line_neg_o <= odd;
         odd        <= ~odd;
      end else if (cnt % (2 * HALF) == HALF) begin
         line_pos_o <= 1'h0;
         line_neg_o <= 1'h0;
      end
   end
endmodule

//--- testbench/t1_e1_liu_digital_side_tb_top.sv
// Self-checking bench of the line interface digital side, with a far-end model.
// Assumes liu_pkg, liu_map.svh and liu_far_end are compiled before it.
`timescale 1ns/1ps
`include "liu_map.svh"
module t1_e1_liu_digital_side_tb_top;
   localparam int LOSS = 300;
   localparam int ZEROS = 8;
   localparam int BITC = 122;
   localparam logic [9:0] P_RXCLK = 10'h001, P_RXP = 10'h002, P_RXN = 10'h004;
   localparam logic [9:0] P_LOS = 10'h008, P_TXP = 10'h010, P_TXN = 10'h020;
   localparam logic [9:0] P_CLKM = 10'h040, P_OVF = 10'h080, P_OE = 10'h100, P_IRQ = 10'h200;
   logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, probe = 1'h0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic        analog = 1'h0, tx_p = 1'h0, tx_n = 1'h0, all_ones = 1'h0, s_hi = 1'h0;
   logic        s_lo = 1'h0, test_n = 1'h1, ovf = 1'h0, tx_run = 1'h1, ja_run = 1'h1;
   logic        marks = 1'h1;
   logic [31:0] rdat;
   logic        ack, irq, rx_clk, rx_p, rx_n, los, ln_p, ln_n, clkm, fovf, oe;
   logic        tck, rck, jck, lp, ln;
   logic [63:0] rd_q[$];
   logic [19:0] pin_q[$];
   int          n_mismatch = 0;
   int          checked = 0;
   wire  [9:0]  obs = {irq, oe, fovf, clkm, ln_n, ln_p, los, rx_n, rx_p, rx_clk};

   t1_e1_liu_digital_side #(.LOS_ZEROS(ZEROS), .CLK_LOSS(LOSS)) i_t1_e1_liu_digital_side (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .line_rx_positive_in_i(lp), .line_rx_negative_in_i(ln),
      .analog_los_i(analog), .tx_clock_in_i(tck), .tx_pos_rail_data_i(tx_p),
      .tx_neg_rail_data_i(tx_n), .external_reference_clock_i(rck),
      .send_all_ones_request_i(all_ones), .loopback_select_hi_i(s_hi),
      .loopback_select_lo_i(s_lo), .in_circuit_test_n_i(test_n), .ja_clock_i(jck),
      .ja_overflow_i(ovf), .rx_clock_o(rx_clk), .rx_pos_rail_data_o(rx_p),
      .rx_neg_rail_data_o(rx_n), .rx_signal_lost_flag_o(los), .line_tx_positive_out_o(ln_p),
      .line_tx_negative_out_o(ln_n), .clock_missing_flag_o(clkm),
      .jitter_buffer_overflow_flag_o(fovf), .pin_oe_o(oe));

   liu_far_end #(.HALF(BITC / 2)) i_liu_far_end (
      .clk_i(clk_i), .tx_run_i(tx_run), .ja_run_i(ja_run), .marks_run_i(marks),
      .tx_clock_o(tck), .ref_clock_o(rck), .ja_clock_o(jck), .line_pos_o(lp), .line_neg_o(ln));

   // The clock inverts every half period of 2 ns.
   always #2 clk_i = ~clk_i;

   task automatic cmp_rd(input logic [63:0] note, input logic [31:0] got);
      checked++;
      if ((got & note[31:0]) !== (note[63:32] & note[31:0])) begin
         n_mismatch++;
         $display("ERROR wb_dat_o expected %h seen %h", note[63:32] & note[31:0], got & note[31:0]);
      end
   endtask

   task automatic cmp_pin(input logic [19:0] note, input logic [9:0] got);
      checked++;
      if ((got & note[9:0]) !== (note[19:10] & note[9:0])) begin
         n_mismatch++;
         $display("ERROR pins expected %h seen %h", note[19:10] & note[9:0], got & note[9:0]);
      end
   endtask

   // Results are judged at mid-cycle, away from the edge that launches them.
   always @(negedge clk_i) begin
      if (ack === 1'h1 && we === 1'h0) begin
         cmp_rd(rd_q.pop_front(), rdat);
      end
      if (probe === 1'h1) begin
         cmp_pin(pin_q.pop_front(), obs);
      end
   end

   // One classic cycle; for a read d is the expected data and m its mask.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] m);
      int n;
      n = 0;
      @(posedge clk_i);
      if (!w) rd_q.push_back({d, m});
      cyc <= 1'h1;
      stb <= 1'h1;
      we  <= w;
      adr <= a;
      dat <= w ? d : 32'h0000_0000;
      sel <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'h1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         $display("ERROR wb_ack_o expected 1 seen 0");
      end
      cyc <= 1'h0;
      stb <= 1'h0;
      we  <= 1'h0;
   endtask

   // Waits c cycles, then notes the expected pins and asks the monitor to look.
   task automatic chk(input int c, input logic [9:0] m, input logic [9:0] v);
      repeat (c) @(posedge clk_i);
      pin_q.push_back({v, m});
      probe <= 1'h1;
      @(posedge clk_i);
      probe <= 1'h0;
   endtask

   task automatic print_verdict();
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // The tests need some 5,500 cycles; 30,000 means the block hung.
   initial begin
      #120000;
      n_mismatch++;
      $display("ERROR watchdog expected done seen timeout");
      print_verdict();
   end

   initial begin
      int          r;
      logic [9:0]  e;
      void'($urandom(48));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(0, `ADR_ENABLE, 32'h0000_0000, 4'hF, 32'h0000_0007);
      wb(0, `ADR_CTRL, 32'h0000_0000, 4'hF, 32'h0000_0001);
      wb(0, 8'h20, 32'h0000_0000, 4'hF, 32'hFFFF_FFFF);
      wb(1, `ADR_ENABLE, 32'h0000_0007, 4'h0, 32'h0000_0000);
      wb(0, `ADR_ENABLE, 32'h0000_0000, 4'hF, 32'h0000_0007);
      r = $urandom_range(7);
      wb(1, `ADR_ENABLE, 32'(r), 4'hF, 32'h0000_0000);
      wb(0, `ADR_ENABLE, 32'(r), 4'hF, 32'h0000_0007);
      wb(1, `ADR_ENABLE, 32'h0000_0000, 4'hF, 32'h0000_0000);
      wb(1, `ADR_CTRL, 32'h0000_0001, 4'hF, 32'h0000_0000);
      wb(0, `ADR_CTRL, 32'h0000_0001, 4'hF, 32'h0000_0001);
      wb(1, `ADR_CTRL, 32'h0000_0000, 4'hF, 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin
         s_hi <= m[1];
         s_lo <= m[0];
         repeat (6) @(posedge clk_i);
         wb(0, `ADR_LIVE, 32'(m) << `LIVE_MODE_LSB, 4'hF, 32'h0000_0030);
      end
      s_hi <= 1'h0;
      s_lo <= 1'h0;
      test_n <= 1'h0;
      chk(6, P_OE, 10'h000);
      test_n <= 1'h1;
      chk(6, P_OE, P_OE);
      ovf <= 1'h1;
      chk(6, P_OVF, P_OVF);
      wb(0, `ADR_EVENT, 32'h0000_0004, 4'hF, 32'h0000_0004);
      ovf <= 1'h0;
      chk(6, P_OVF, 10'h000);
      // Rails change at the falling transmit clock and are sent after the rise.
      for (int i = 0; i < 4; i++) begin
         @(negedge tck);
         @(posedge clk_i);
         r = $urandom_range(2);
         tx_p <= (r == 1);
         tx_n <= (r == 2);
         @(posedge tck);
         e = (r == 1) ? P_TXP : (r == 2) ? P_TXN : 10'h000;
         chk(8, P_TXP | P_TXN, e);
      end
      // Digital loopback shows the last captured transmit rails on the receive rails.
      s_lo <= 1'h1;
      chk(8, P_RXP | P_RXN, e >> 3);
      s_lo <= 1'h0;
      @(negedge rck);
      @(posedge clk_i);
      all_ones <= 1'h1;
      for (int k = 0; k < 4; k++) begin
         @(posedge rck);
         chk(8, P_TXP | P_TXN, k[0] ? P_TXN : P_TXP);
      end
      // Local loopback: the fifth all-ones mark is positive and comes back on the rx rails.
      s_hi <= 1'h1;
      s_lo <= 1'h1;
      @(posedge rck);
      chk(80, P_RXP | P_RXN | P_TXP | P_TXN, P_RXP | P_TXP);
      // Remote loopback with the all-ones request still high.
      s_lo <= 1'h0;
      repeat (400) @(posedge clk_i);
      for (int k = 0; k < 2; k++) begin
         @(posedge (k == 0 ? lp : ln));
         chk(20, P_RXCLK, P_RXCLK);
         e = k ? (P_RXN | P_TXN) : (P_RXP | P_TXP);
         chk(80, P_RXCLK | P_RXP | P_RXN | P_TXP | P_TXN | P_LOS, e);
      end
      marks <= 1'h0;
      chk(ZEROS * BITC + 300, P_LOS, P_LOS);
      marks <= 1'h1;
      chk(300, P_LOS, 10'h000);
      analog <= 1'h1;
      chk(6, P_LOS, P_LOS);
      wb(1, `ADR_ENABLE, 32'h0000_0001, 4'hF, 32'h0000_0000);
      wb(0, `ADR_EVENT, 32'h0000_0001, 4'hF, 32'h0000_0001);
      chk(1, P_IRQ, P_IRQ);
      wb(1, `ADR_ENABLE, 32'h0000_0000, 4'hF, 32'h0000_0000);
      chk(1, P_IRQ, 10'h000);
      wb(1, `ADR_ENABLE, 32'h0000_0001, 4'hF, 32'h0000_0000);
      wb(1, `ADR_CLEAR, 32'h0000_0001, 4'hF, 32'h0000_0000);
      chk(1, P_IRQ, 10'h000);
      analog <= 1'h0;
      chk(6, P_LOS, 10'h000);
      for (int c = 0; c < 2; c++) begin
         tx_run <= (c != 0);
         ja_run <= (c == 0);
         chk(LOSS + 150, P_CLKM, P_CLKM);
         tx_run <= 1'h1;
         ja_run <= 1'h1;
         chk(300, P_CLKM, 10'h000);
      end
      print_verdict();
   end
endmodule
